/* File: shared/nbh_pkg.sv */
// Package with pin groups, command codes and timing counts for the NAND page read host.
package nbh_pkg;
  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_COL_CHANGE = 8'h05;
  localparam logic [7:0] CMD_COL_CONFIRM = 8'he0;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  // ---------------------------------------------------------------
  // Address layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 27;
  localparam int ADDR_CYCLES = 4;
  localparam int COL_W = 11;
  localparam int COL_CYCLES = 2;
  localparam int PAGE_WORDS = 1056;
  localparam int DATA_W = 16;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS = 30;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_LOAD_TIME_NS = 25000;
  localparam int PAGE_LOAD_CYC = PAGE_LOAD_TIME_NS / CLK_PERIOD_NS;
  localparam int RB_SETTLE_NS = 100;
  localparam int RB_SETTLE_CYC = (RB_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Pins driven toward the flash.
  typedef struct packed {
    logic chip_en_n;
    logic cmd_latch;
    logic addr_latch;
    logic write_strobe_n;
    logic read_strobe_n;
    logic write_prot_n;
  } nbh_ctl_t;

  // One host request.
  typedef struct packed {
    logic col_only;
    logic [ADDR_W-1:0] addr;
  } nbh_req_t;
endpackage

/* File: sim/nbh_flash_model.sv */
// Behavioural flash device that answers page reads on the host pins.
`timescale 1ns/1ps
module nbh_flash_model #(
  parameter int LOAD_CYCLES = 20
) (
  input wire logic clk,
  input wire nbh_pkg::nbh_ctl_t pins,
  input wire logic [15:0] host_io,
  output logic [15:0] dev_io,
  output logic ready_busy_n
);
  logic [26:0] addr_r = '0;
  logic [15:0] page_r = '0;
  logic [10:0] col_r = '0;
  logic [1:0] acnt_r = '0;
  logic we_r = 1'b1;
  logic re_r = 1'b1;
  int busy_r = 0;
  int prog_words = 0;
  logic rise;
  initial dev_io = '0;
  assign ready_busy_n = (busy_r == 0);
  assign rise = pins.write_strobe_n && !we_r && !pins.chip_en_n && pins.read_strobe_n;
  always @(posedge clk) begin
    we_r <= pins.write_strobe_n;
    re_r <= pins.read_strobe_n;
    if (busy_r > 0) busy_r <= busy_r - 1;
    if (rise && pins.cmd_latch && !pins.addr_latch && busy_r == 0) begin
      acnt_r <= '0;
      if (host_io[7:0] == nbh_pkg::CMD_READ_CONFIRM) begin
        page_r <= addr_r[26:11];
        col_r <= addr_r[10:0];
        busy_r <= LOAD_CYCLES;
      end
      if (host_io[7:0] == nbh_pkg::CMD_COL_CONFIRM) col_r <= addr_r[10:0];
    end
    if (rise && pins.addr_latch && !pins.cmd_latch) begin
      acnt_r <= acnt_r + 2'h1;
      case (acnt_r)
        2'h0: addr_r[7:0] <= host_io[7:0];
        2'h1: addr_r[10:8] <= host_io[2:0];
        2'h2: addr_r[18:11] <= host_io[7:0];
        default: addr_r[26:19] <= host_io[7:0];
      endcase
    end
    // Protection is read straight from the pin, so no earlier strobe can unlock it.
    if (rise && !pins.cmd_latch && !pins.addr_latch && pins.write_prot_n) begin
      prog_words <= prog_words + 1;
    end
    // Stale data is inverted so a host sampling late cannot see a lucky match.
    if (pins.chip_en_n || (pins.read_strobe_n && !re_r)) dev_io <= ~dev_io;
    else if (!pins.read_strobe_n && re_r && pins.write_strobe_n) begin
      dev_io <= {page_r[4:0], col_r};
      col_r <= col_r + 11'h1;
    end
  end
endmodule

/* File: sim/nbh_host_assertions.sv */
// Concurrent checks on the page read host flash pins.
`timescale 1ns/1ps
module nbh_host_assertions #(
  parameter int PAGE_LOAD_CYCLES = 20,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire nbh_pkg::nbh_req_t req,
  input wire logic busy,
  input wire nbh_pkg::nbh_ctl_t pins,
  input wire logic [15:0] io_out,
  input wire logic io_oe,
  input wire logic ready_busy_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence setup_s;
    pins.cmd_latch && io_oe && io_out[7:0] == nbh_pkg::CMD_READ_SETUP;
  endsequence
  sequence low_s;
    !pins.read_strobe_n [*3] ##1 pins.read_strobe_n;
  endsequence
  upper_lanes_a: assert property (
    (pins.cmd_latch || pins.addr_latch) && io_oe |-> io_out[15:8] == 8'h00) else $error("upper");
  latch_excl_a: assert property (!(pins.cmd_latch && pins.addr_latch)) else $error("latch");
  cmd_edge_a: assert property (
    $rose(pins.write_strobe_n) && pins.cmd_latch |-> !pins.chip_en_n && pins.read_strobe_n)
    else $error("cmd edge");
  addr_edge_a: assert property (
    $rose(pins.write_strobe_n) && pins.addr_latch |-> !pins.chip_en_n && pins.read_strobe_n)
    else $error("addr edge");
  strobe_latch_a: assert property (
    $rose(pins.write_strobe_n) |-> pins.cmd_latch != pins.addr_latch) else $error("latch at rise");
  read_cond_a: assert property ($fell(pins.read_strobe_n) |->
    pins.write_strobe_n && !pins.cmd_latch && !pins.addr_latch && !pins.chip_en_n && !io_oe)
    else $error("read cond");
  strobe_low_a: assert property ($fell(pins.read_strobe_n) |-> low_s) else $error("width");
  wait_ready_a: assert property ($fell(pins.read_strobe_n) |-> ready_busy_n) else $error("rb");
  setup_first_a: assert property (
    req_valid && req_ready && !req.col_only |=> ##[0:3] setup_s) else $error("setup");
  prot_low_a: assert property (pins.write_prot_n == 1'b0) else $error("protect");
endmodule
bind nbh_host nbh_host_assertions #(.PAGE_LOAD_CYCLES(PAGE_LOAD_CYCLES), .FIFO_DEPTH(FIFO_DEPTH))
  chk (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .busy(busy), .pins(pins), .io_out(io_out), .io_oe(io_oe), .ready_busy_n(ready_busy_n));

/* File: sim/tb_nbh_host.sv */
// Testbench for the page read host against a behavioural flash device.
`timescale 1ns/1ps
module tb_nbh_host;
  localparam int LOAD = 20;
  typedef struct {logic c; logic [26:0] a; logic [10:0] n; logic [15:0] w;} nbh_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic rd_ready = 1'b0;
  nbh_pkg::nbh_req_t req = '0;
  logic [10:0] req_words = '0;
  logic req_ready, rd_valid, busy, io_oe, rb_n;
  logic [15:0] rd_data, io_out, io_in;
  nbh_pkg::nbh_ctl_t pins;
  int mismatches = 0;
  int total_checks = 0;
  // Each row: column-only flag, address, word count, first expected word.
  nbh_row_t rows [5] = '{
    '{1'b0, {16'h0005, 11'h000}, 11'h003, 16'h2800},
    '{1'b0, {16'h0005, 11'h41a}, 11'h006, 16'h2c1a},
    '{1'b1, {16'h0005, 11'h005}, 11'h004, 16'h2805},
    '{1'b1, {16'h0005, 11'h3e8}, 11'h002, 16'h2be8},
    '{1'b0, {16'h0009, 11'h010}, 11'h005, 16'h4810}};
  always #5 clk = ~clk;
  nbh_host #(.PAGE_LOAD_CYCLES(LOAD), .FIFO_DEPTH(8)) uut (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .req_words(req_words),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy), .pins(pins),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .ready_busy_n(rb_n));
  nbh_flash_model #(.LOAD_CYCLES(LOAD)) dev (.clk(clk), .pins(pins), .host_io(io_out),
    .dev_io(io_in), .ready_busy_n(rb_n));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic send(input logic c, input logic [26:0] a, input logic [10:0] n);
    @(posedge clk);
    req <= {c, a};
    req_words <= n;
    req_valid <= 1'b1;
    #1;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  // Expected word: low page bits above the column, column counting up from the first word.
  task automatic collect(input logic [15:0] first, input int n);
    int i;
    i = 0;
    while (i < n) begin
      @(posedge clk);
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        check_word(rd_data, {first[15:11], first[10:0] + 11'(i)});
        i++;
      end
    end
  endtask
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_ready <= 1'b1;
    foreach (rows[i]) begin
      send(rows[i].c, rows[i].a, rows[i].n);
      collect(rows[i].w, int'(rows[i].n));
    end
    rd_ready <= 1'b0;
    send(1'b0, {16'h0012, 11'h020}, 11'h00c);
    repeat (150) @(posedge clk);
    #1;
    check_bit(busy, 1'b1);
    check_bit(rd_valid, 1'b1);
    check_bit(req_ready, 1'b0);
    @(posedge clk);
    rd_ready <= 1'b1;
    collect(16'h9020, 12);
    send(1'b0, {16'h0003, 11'h000}, 11'h004);
    repeat (30) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_bit(pins.chip_en_n, 1'b1);
    check_bit(io_oe, 1'b0);
    check_bit(rd_valid, 1'b0);
    check_bit(req_ready, 1'b1);
    @(posedge clk);
    rst <= 1'b0;
    repeat (LOAD + 5) @(posedge clk);
    send(1'b1, {16'h0007, 11'h011}, 11'h003);
    collect(16'h3811, 3);
    send(1'b0, {16'h0003, 11'h000}, 11'h000);
    repeat (80) @(posedge clk);
    #1;
    check_bit(busy, 1'b0);
    check_bit(rd_valid, 1'b0);
    send(1'b1, {16'h0003, 11'h004}, 11'h002);
    collect(16'h1804, 2);
    check_bit(dev.prog_words == 0, 1'b1);
    report_and_stop;
  end
endmodule

/* File: verilog/nbh_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module nbh_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("nbh_fifo depth must be a power of two, at least 2");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  assign in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule

/* File: verilog/nbh_host.sv */
// Host controller that reads NAND pages over the flash pins into a word FIFO.
// Contract
// - Send full 27-bit address in four cycles
// - Address bytes on low lines, unused low
// - Commands and addresses on low lines only
// - Hold write protect high for modify sequences
// - Page read is 00h, address, 30h
`timescale 1ns/1ps
module nbh_host #(
  parameter int PAGE_LOAD_CYCLES = nbh_pkg::PAGE_LOAD_CYC,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Read request: full address, or column only within the loaded page
  input wire logic req_valid,
  output logic req_ready,
  input wire nbh_pkg::nbh_req_t req,
  input wire logic [10:0] req_words,
  // Read data stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [nbh_pkg::DATA_W-1:0] rd_data,
  output logic busy,
  // Flash pins
  output nbh_pkg::nbh_ctl_t pins,
  input wire logic [nbh_pkg::DATA_W-1:0] io_in,
  output logic [nbh_pkg::DATA_W-1:0] io_out,
  output logic io_oe,
  input wire logic ready_busy_n
);
  initial begin
    if (PAGE_LOAD_CYCLES < 1 || PAGE_LOAD_CYCLES > 65535) begin
      $error("nbh_host page load count must be positive and fit the wait counter");
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD1, ST_ADDR, ST_CMD2, ST_SETTLE, ST_WAIT, ST_READ, ST_PUSH
  } nbh_state_t;

  nbh_state_t state_r, state_nxt;
  nbh_pkg::nbh_req_t req_r, req_nxt;
  nbh_pkg::nbh_ctl_t pins_r, pins_nxt;
  logic [nbh_pkg::DATA_W-1:0] io_out_r, io_out_nxt;
  logic io_oe_r, io_oe_nxt;
  logic [2:0] acnt_r, acnt_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [15:0] wait_r, wait_nxt;
  logic [10:0] left_r, left_nxt;
  logic [nbh_pkg::DATA_W-1:0] word_r, word_nxt;
  logic [nbh_pkg::COL_W-1:0] col;
  logic page_loaded_r, page_loaded_nxt;
  logic f_valid, f_ready;
  logic [7:0] addr_byte;

  assign pins = pins_r;
  assign io_out = io_out_r;
  assign io_oe = io_oe_r;
  assign req_ready = (state_r == ST_IDLE);
  assign busy = (state_r != ST_IDLE);
  assign f_valid = (state_r == ST_PUSH);
  assign col = req_r.addr[nbh_pkg::COL_W-1:0];

  // Address cycle map, lowest bits first, unused lines low.
  always_comb begin
    case (acnt_r)
      3'h0: addr_byte = col[7:0];
      3'h1: addr_byte = {5'h00, col[10:8]};
      3'h2: addr_byte = req_r.addr[18:11];
      3'h3: addr_byte = req_r.addr[26:19];
      default: addr_byte = 8'h00;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    pins_nxt = pins_r;
    io_out_nxt = io_out_r;
    io_oe_nxt = io_oe_r;
    acnt_nxt = acnt_r;
    ph_nxt = ph_r;
    wait_nxt = wait_r;
    left_nxt = left_r;
    word_nxt = word_r;
    page_loaded_nxt = page_loaded_r;
    // A read never starts a modify operation, so protection stays asserted.
    pins_nxt.write_prot_n = 1'b0;
    case (state_r)
      ST_IDLE: begin
        pins_nxt = '{chip_en_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0,
                     write_strobe_n: 1'b1, read_strobe_n: 1'b1, write_prot_n: 1'b0};
        io_oe_nxt = 1'b0;
        if (req_valid) begin
          req_nxt = req;
          // A column-only request needs a page already loaded by a full read.
          req_nxt.col_only = req.col_only && page_loaded_r;
          left_nxt = req_words;
          acnt_nxt = '0;
          ph_nxt = '0;
          state_nxt = ST_CMD1;
        end
      end
      ST_CMD1, ST_CMD2: begin
        ph_nxt = ph_r + 2'h1;
        pins_nxt.chip_en_n = 1'b0;
        pins_nxt.cmd_latch = 1'b1;
        pins_nxt.addr_latch = 1'b0;
        io_oe_nxt = 1'b1;
        if (state_r == ST_CMD1) begin
          io_out_nxt = {8'h00, req_r.col_only ? nbh_pkg::CMD_COL_CHANGE
                                              : nbh_pkg::CMD_READ_SETUP};
        end else begin
          io_out_nxt = {8'h00, req_r.col_only ? nbh_pkg::CMD_COL_CONFIRM
                                              : nbh_pkg::CMD_READ_CONFIRM};
        end
        pins_nxt.write_strobe_n = (ph_r == 2'h0 || ph_r == 2'h3);
        if (ph_r == 2'h3) begin
          // The latch enable stays up through the strobe rise; the next state drops it.
          ph_nxt = '0;
          state_nxt = (state_r == ST_CMD1) ? ST_ADDR : ST_SETTLE;
          wait_nxt = '0;
        end
      end
      ST_ADDR: begin
        ph_nxt = ph_r + 2'h1;
        pins_nxt.addr_latch = 1'b1;
        pins_nxt.cmd_latch = 1'b0;
        io_oe_nxt = 1'b1;
        io_out_nxt = {8'h00, addr_byte};
        pins_nxt.write_strobe_n = (ph_r == 2'h0 || ph_r == 2'h3);
        if (ph_r == 2'h3) begin
          ph_nxt = '0;
          acnt_nxt = acnt_r + 3'h1;
          if (acnt_r == 3'(req_r.col_only ? nbh_pkg::COL_CYCLES - 1
                                            : nbh_pkg::ADDR_CYCLES - 1)) begin
            state_nxt = ST_CMD2;
          end
        end
      end
      ST_SETTLE: begin
        // Ready/busy may lag the confirm strobe; wait before sampling it.
        io_oe_nxt = 1'b0;
        pins_nxt.cmd_latch = 1'b0;
        wait_nxt = wait_r + 16'h1;
        if (wait_r == 16'(nbh_pkg::RB_SETTLE_CYC)) begin
          wait_nxt = '0;
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        wait_nxt = wait_r + 16'h1;
        if (ready_busy_n || wait_r == 16'(PAGE_LOAD_CYCLES)) begin
          page_loaded_nxt = 1'b1;
          ph_nxt = '0;
          state_nxt = (left_r == '0) ? ST_IDLE : ST_READ;
        end
      end
      ST_READ: begin
        ph_nxt = ph_r + 2'h1;
        pins_nxt.read_strobe_n = (ph_r == 2'h3);
        if (ph_r == 2'h3) begin
          word_nxt = io_in;
          state_nxt = ST_PUSH;
        end
      end
      ST_PUSH: begin
        ph_nxt = '0;
        if (f_ready) begin
          left_nxt = left_r - 11'h1;
          state_nxt = (left_r == 11'h1) ? ST_IDLE : ST_READ;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      req_r <= '0;
      pins_r <= '{chip_en_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0,
                  write_strobe_n: 1'b1, read_strobe_n: 1'b1, write_prot_n: 1'b0};
      io_out_r <= '0;
      io_oe_r <= 1'b0;
      acnt_r <= '0;
      ph_r <= '0;
      wait_r <= '0;
      left_r <= '0;
      word_r <= '0;
      page_loaded_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      pins_r <= pins_nxt;
      io_out_r <= io_out_nxt;
      io_oe_r <= io_oe_nxt;
      acnt_r <= acnt_nxt;
      ph_r <= ph_nxt;
      wait_r <= wait_nxt;
      left_r <= left_nxt;
      word_r <= word_nxt;
      page_loaded_r <= page_loaded_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read data buffer
  // ---------------------------------------------------------------
  nbh_fifo #(.WIDTH(nbh_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(f_valid),
    .in_ready(f_ready),
    .in_data(word_r),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
endmodule
